// file: asp_checker.sv
// Port-level assertions for the autobuffered serial port.
// Bound to every asp_serial_port; all checks live in the clk domain.
`timescale 1ns/10ps
`default_nettype none
module asp_checker (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        cpu_tx_wr,
   input wire logic [15:0] cpu_tx_wdata,
   input wire logic [15:0] tx_data_reg,
   input wire logic        tx_full,
   input wire logic        ab_rx_en,
   input wire logic        ab_auto_dis,
   input wire logic [10:0] ab_rx_start,
   input wire logic [10:0] ab_rx_len_m1,
   input wire logic        ab_tx_active,
   input wire logic        ab_rx_active,
   input wire logic [10:0] ab_rx_ptr,
   input wire logic [15:0] mem_addr,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic        tx_int_en,
   input wire logic        rx_int_en,
   input wire logic        tx_interrupt,
   input wire logic        rx_interrupt,
   input wire logic        misalign_interrupt,
   input wire logic        tx_word_event,
   input wire logic        rx_word_event
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_TX_ACCEPT: assert property (
      cpu_tx_wr && !tx_full && !ab_tx_active |=> tx_full
      && tx_data_reg == $past(cpu_tx_wdata))
      else $error("transmit write not taken");
   AST_TX_REFUSE: assert property (
      cpu_tx_wr && tx_full && !ab_tx_active |=> $stable(tx_data_reg))
      else $error("write to full transmit register changed it");
   AST_TX_PASS: assert property (
      tx_word_event && tx_int_en && !ab_tx_active |-> tx_interrupt)
      else $error("transmit word event not passed on");
   AST_RX_PASS: assert property (
      rx_word_event && rx_int_en && !ab_rx_active |-> rx_interrupt)
      else $error("receive word event not passed on");
   AST_INT_MASK: assert property (
      !tx_int_en && !$past(tx_int_en) |-> !tx_interrupt)
      else $error("masked transmit interrupt raised");
   AST_AB_WRITE: assert property (
      ab_rx_active && rx_word_event |-> mem_wr)
      else $error("autobuffered word not written to memory");
   // Only the last buffer slot may signal; earlier words stay quiet
   AST_AB_QUIET: assert property (
      ab_rx_active && rx_word_event
      && mem_addr[10:0] != 11'(ab_rx_start + ab_rx_len_m1) |-> !rx_interrupt)
      else $error("per-word interrupt while autobuffering");
   AST_MEM_WIN: assert property (
      mem_rd || mem_wr |-> mem_addr[15:11] == asp_pkg::ABU_REGION_BASE[15:11])
      else $error("memory access outside buffer window");
   AST_MEM_ONE: assert property (!(mem_rd && mem_wr))
      else $error("read and write on one memory cycle");
   AST_AB_ARM: assert property (
      $rose(ab_rx_en) |-> ##[1:2] (ab_rx_active && ab_rx_ptr == ab_rx_start))
      else $error("receive autobuffer not armed at start");
   AST_AUTO_DIS: assert property (
      $past(ab_auto_dis) && rx_interrupt && $past(ab_rx_active)
      |-> !ab_rx_active)
      else $error("autobuffer not stopped at wrap");

   cover property (ab_rx_active && rx_interrupt);
   cover property (misalign_interrupt);
   cover property (cpu_tx_wr && tx_full);
endmodule

bind asp_serial_port asp_checker asp_checker_inst (.*);
`default_nettype wire

// file: asp_codec_model.sv
// Codec on the link side: makes both link clocks, syncs and receive data.
// Clocks stand still outside frame() and pulse(), which the bench calls.
`timescale 1ns/10ps
`default_nettype none
module asp_codec_model (
   output logic      tx_bclk,
   output logic      tx_fsync,
   input  wire logic tx_dout,
   output logic      rx_bclk,
   output logic      rx_fsync,
   output logic      rx_din,
   input  wire logic fs_pol
);
   logic [15:0] rx_w [4];
   logic [15:0] tx_w [4];
   logic        t;
   // Sync sense lags a polarity change by two edges, as the port does
   logic [1:0]  pd = 2'h0;

   initial begin
      {tx_bclk, tx_fsync, rx_bclk, rx_fsync, rx_din, t} = 6'h00;
   end

   // One 6 ns link period; transmit bit is read where it has settled
   task automatic tick(input logic fs, input logic d);
      tx_fsync = fs ^ pd[1];
      rx_fsync = fs ^ pd[1];
      rx_din = d;
      #3;
      {tx_bclk, rx_bclk} = 2'h3;
      pd = {pd[0], fs_pol};
      #3;
      {tx_bclk, rx_bclk} = 2'h0;
      t = tx_dout;
   endtask

   task automatic pulse();
      repeat (6) tick(1'b0, 1'b0);
   endtask

   // Lead-in edges let the port pick up a pending word before the sync
   task automatic frame(input int nw, input int nb, input bit cont);
      for (int w = 0; w < nw; w++) begin
         if (w == 0 || !cont) begin
            repeat (4) tick(1'b0, ~rx_din);
            tick(1'b1, ~rx_din);
         end
         tx_w[w] = 16'h0000;
         for (int b = nb - 1; b >= 0; b--) begin
            tx_w[w][b] = t;
            tick(1'b0, rx_w[w][b]);
         end
      end
   endtask
endmodule
`default_nettype wire

// file: asp_pkg.sv
// Constants, state types and helpers for the autobuffered serial port.
// Assumes a single-port synchronous on-chip memory with one-cycle read data.
package asp_pkg;

   localparam int unsigned WORD_W = 16;
   localparam int unsigned PTR_W  = 11;

   // Autobuffers live in one 2K-word window of internal memory
   localparam logic [15:0] ABU_REGION_BASE = 16'h0800;

   localparam logic [1:0] LEN_8  = 2'h0;
   localparam logic [1:0] LEN_10 = 2'h1;
   localparam logic [1:0] LEN_12 = 2'h2;
   localparam logic [1:0] LEN_16 = 2'h3;

   localparam logic [4:0] BITS_8  = 5'h08;
   localparam logic [4:0] BITS_10 = 5'h0a;
   localparam logic [4:0] BITS_12 = 5'h0c;
   localparam logic [4:0] BITS_16 = 5'h10;
   localparam logic [4:0] CNT_LAST = 5'h01;

   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic [10:0] PTR_RST  = 11'h000;
   localparam logic [10:0] PTR_ONE  = 11'h001;
   localparam logic [7:0]  DIV_RST  = 8'h00;
   localparam logic [7:0]  DIV_ONE  = 8'h01;
   localparam logic [4:0]  CNT_RST  = 5'h00;

   typedef enum logic [0:0] {
      ASP_IDLE  = 1'b0,
      ASP_SHIFT = 1'b1
   } asp_link_st_t;

   typedef struct packed {
      logic         rst1, rst2;
      logic [1:0]   len1, len2;
      logic         cont1, cont2, fpol1, fpol2;
      logic         req1, req2, ack;
      logic [15:0]  pend;
      logic         pend_v;
      asp_link_st_t st;
      logic [15:0]  sh;
      logic [4:0]   cnt;
      logic         fs_tog;
   } asp_txl_t;

   typedef struct packed {
      logic         rst1, rst2;
      logic [1:0]   len1, len2;
      logic         cont1, cont2, fpol1, fpol2;
      asp_link_st_t st;
      logic [15:0]  sh;
      logic [4:0]   cnt;
      logic [15:0]  hold;
      logic         word_tog;
      logic         fs_tog;
   } asp_rxl_t;

   typedef struct packed {
      logic        tack1, tack2;
      logic        tfs1, tfs2, tfs3;
      logic        rw1, rw2, rw3;
      logic        rfs1, rfs2, rfs3;
      logic [15:0] tx_reg;
      logic        tx_full, tx_req;
      logic [15:0] rx_reg;
      logic        rx_full;
      logic        tx_en_d, rx_en_d, tx_act, rx_act;
      logic [10:0] tx_ptr, rx_ptr;
      logic [15:0] mem_addr, mem_wdata;
      logic        mem_rd, mem_wr, rd_cap;
      logic [7:0]  div_cnt, fs_cnt;
      logic        bit_lvl, gbclk, gfs;
      logic        tx_int, rx_int, mis_int, tx_wev, rx_wev;
   } asp_clk_t;

   localparam asp_clk_t CLK_RST = '0;

   function automatic logic [4:0] asp_bits(input logic [1:0] len);
      logic [4:0] b;
      b = BITS_16;
      unique case (len)
         LEN_8:  b = BITS_8;
         LEN_10: b = BITS_10;
         LEN_12: b = BITS_12;
         LEN_16: b = BITS_16;
      endcase
      return b;
   endfunction

   // Circular step: {wrapped, next pointer}; len_m1 is length minus one
   function automatic logic [11:0] asp_adv(input logic [10:0] ptr,
                                           input logic [10:0] start,
                                           input logic [10:0] len_m1);
      logic [10:0] last;
      last = 11'(start + len_m1);
      if (ptr == last)
         return {1'b1, start};
      return {1'b0, 11'(ptr + PTR_ONE)};
   endfunction

endpackage

// file: asp_serial_port.sv
// Buffered serial port with autobuffering unit, transmit and receive links.
// Assumes link clocks from the partner, link pins synchronous to them, and
// a dedicated single-port memory returning read data one cycle after mem_rd.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Transmit and receive data registers software accessible
// - Separate clock, sync, shifter per direction
// - Byte or full 16-bit word transfers
// - Separate maskable transmit and receive interrupts
// - Double-buffered, static, any slow bit clock
// - Autobuffer uses own dedicated memory port
// - Autobuffer off: word events become interrupts
// - Autobuffer on: words moved directly to memory
// - Circular buffers, programmable start/length, 2K window
// - Interrupt on transmit empty, receive full
// - Optional automatic disable at buffer wrap
// - Independent transmit and receive autobuffer enables
// - Packet lengths 8, 10, 12, 16 bits
// - Burst mode: one sync per packet
// - Continuous mode: one sync, then back-to-back
// - Programmable clock and sync frequency, polarity
// - Sync off buffer top raises misalign interrupt
module asp_serial_port (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        tx_bclk,
   input  wire logic        tx_fsync,
   output logic             tx_dout,
   input  wire logic        rx_bclk,
   input  wire logic        rx_fsync,
   input  wire logic        rx_din,
   input  wire logic [1:0]  cfg_len,
   input  wire logic        cfg_continuous,
   input  wire logic        cfg_fs_pol,
   input  wire logic        cfg_clk_pol,
   input  wire logic [7:0]  cfg_clk_div,
   input  wire logic [7:0]  cfg_fs_period,
   output logic             gen_bclk,
   output logic             gen_fsync,
   input  wire logic        cpu_tx_wr,
   input  wire logic [15:0] cpu_tx_wdata,
   input  wire logic        cpu_rx_rd,
   output logic [15:0]      tx_data_reg,
   output logic [15:0]      rx_data_reg,
   output logic             tx_full,
   output logic             rx_full,
   input  wire logic        ab_tx_en,
   input  wire logic        ab_rx_en,
   input  wire logic        ab_auto_dis,
   input  wire logic [10:0] ab_tx_start,
   input  wire logic [10:0] ab_tx_len_m1,
   input  wire logic [10:0] ab_rx_start,
   input  wire logic [10:0] ab_rx_len_m1,
   output logic             ab_tx_active,
   output logic             ab_rx_active,
   output logic [10:0]      ab_tx_ptr,
   output logic [10:0]      ab_rx_ptr,
   output logic [15:0]      mem_addr,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic [15:0]      mem_wdata,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        tx_int_en,
   input  wire logic        rx_int_en,
   input  wire logic        misalign_int_en,
   output logic             tx_interrupt,
   output logic             rx_interrupt,
   output logic             misalign_interrupt,
   output logic             tx_word_event,
   output logic             rx_word_event
);

   asp_pkg::asp_txl_t tl_r;
   asp_pkg::asp_txl_t tl_nxt;
   asp_pkg::asp_rxl_t rl_r;
   asp_pkg::asp_rxl_t rl_nxt;
   asp_pkg::asp_clk_t cl_r;
   asp_pkg::asp_clk_t cl_nxt;

   // Transmit link, on the transmit bit clock
   always_comb begin
      logic       fs;
      logic       go;
      logic [4:0] bits;
      fs   = 1'b0;
      go   = 1'b0;
      bits = asp_pkg::BITS_16;
      tl_nxt       = tl_r;
      tl_nxt.rst1  = reset;
      tl_nxt.rst2  = tl_r.rst1;
      // Config crosses as levels; change it only while the link is idle
      tl_nxt.len1  = cfg_len;
      tl_nxt.len2  = tl_r.len1;
      tl_nxt.cont1 = cfg_continuous;
      tl_nxt.cont2 = tl_r.cont1;
      tl_nxt.fpol1 = cfg_fs_pol;
      tl_nxt.fpol2 = tl_r.fpol1;
      tl_nxt.req1  = cl_r.tx_req;
      tl_nxt.req2  = tl_r.req1;
      if (tl_r.rst2) begin
         tl_nxt.ack    = 1'b0;
         tl_nxt.pend   = asp_pkg::DATA_RST;
         tl_nxt.pend_v = 1'b0;
         tl_nxt.st     = asp_pkg::ASP_IDLE;
         tl_nxt.sh     = asp_pkg::DATA_RST;
         tl_nxt.cnt    = asp_pkg::CNT_RST;
         tl_nxt.fs_tog = 1'b0;
      end else begin
         fs   = tx_fsync ^ tl_r.fpol2;
         bits = asp_pkg::asp_bits(tl_r.len2);
         unique case (tl_r.st)
            asp_pkg::ASP_IDLE: begin
               go = fs;
            end
            asp_pkg::ASP_SHIFT: begin
               tl_nxt.sh  = {tl_r.sh[14:0], 1'b0};
               tl_nxt.cnt = 5'(tl_r.cnt - asp_pkg::CNT_LAST);
               if (tl_r.cnt == asp_pkg::CNT_LAST) begin
                  tl_nxt.st = asp_pkg::ASP_IDLE;
                  if (tl_r.cont2) begin
                     go = tl_r.pend_v;
                  end else begin
                     go = fs;
                  end
               end
            end
         endcase
         // Word held by the clock side stays stable until ack returns
         if (tl_r.req2 != tl_r.ack && (!tl_r.pend_v || go)) begin
            tl_nxt.pend   = cl_r.tx_reg;
            tl_nxt.pend_v = 1'b1;
            tl_nxt.ack    = tl_r.req2;
         end else if (go) begin
            tl_nxt.pend_v = 1'b0;
         end
         if (go) begin
            tl_nxt.st  = asp_pkg::ASP_SHIFT;
            tl_nxt.cnt = bits;
            // Underrun sends zeros rather than a stale word
            tl_nxt.sh  = tl_r.pend_v ?
                         16'(tl_r.pend << 5'(5'h10 - bits)) :
                         asp_pkg::DATA_RST;
            if (fs && (tl_r.st == asp_pkg::ASP_IDLE || !tl_r.cont2)) begin
               tl_nxt.fs_tog = ~tl_r.fs_tog;
            end
         end
      end
   end

   always_ff @(posedge tx_bclk) begin
      tl_r <= tl_nxt;
   end

   // Receive link, on the receive bit clock
   always_comb begin
      logic        fs;
      logic [4:0]  bits;
      logic [15:0] shin;
      fs   = 1'b0;
      bits = asp_pkg::BITS_16;
      shin = asp_pkg::DATA_RST;
      rl_nxt       = rl_r;
      rl_nxt.rst1  = reset;
      rl_nxt.rst2  = rl_r.rst1;
      rl_nxt.len1  = cfg_len;
      rl_nxt.len2  = rl_r.len1;
      rl_nxt.cont1 = cfg_continuous;
      rl_nxt.cont2 = rl_r.cont1;
      rl_nxt.fpol1 = cfg_fs_pol;
      rl_nxt.fpol2 = rl_r.fpol1;
      if (rl_r.rst2) begin
         rl_nxt.st       = asp_pkg::ASP_IDLE;
         rl_nxt.sh       = asp_pkg::DATA_RST;
         rl_nxt.cnt      = asp_pkg::CNT_RST;
         rl_nxt.hold     = asp_pkg::DATA_RST;
         rl_nxt.word_tog = 1'b0;
         rl_nxt.fs_tog   = 1'b0;
      end else begin
         fs   = rx_fsync ^ rl_r.fpol2;
         bits = asp_pkg::asp_bits(rl_r.len2);
         shin = {rl_r.sh[14:0], rx_din};
         unique case (rl_r.st)
            asp_pkg::ASP_IDLE: begin
               if (fs) begin
                  rl_nxt.st     = asp_pkg::ASP_SHIFT;
                  rl_nxt.cnt    = bits;
                  rl_nxt.fs_tog = ~rl_r.fs_tog;
               end
            end
            asp_pkg::ASP_SHIFT: begin
               rl_nxt.sh  = shin;
               rl_nxt.cnt = 5'(rl_r.cnt - asp_pkg::CNT_LAST);
               if (rl_r.cnt == asp_pkg::CNT_LAST) begin
                  // Hold stays put a whole packet, time for the crossing
                  rl_nxt.hold     = shin & 16'(17'h1ffff >> 5'(5'h11 - bits));
                  rl_nxt.word_tog = ~rl_r.word_tog;
                  if (rl_r.cont2) begin
                     rl_nxt.cnt = bits;
                  end else if (fs) begin
                     rl_nxt.cnt    = bits;
                     rl_nxt.fs_tog = ~rl_r.fs_tog;
                  end else begin
                     rl_nxt.st = asp_pkg::ASP_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge rx_bclk) begin
      rl_r <= rl_nxt;
   end

   // Processor side: data registers, autobuffer unit, clock generator
   always_comb begin
      logic        tx_wev, rx_wev, tx_fse, rx_fse, rx_new;
      logic        tx_bufe, rx_buff;
      logic [11:0] adv;
      adv     = 12'h000;
      tx_bufe = 1'b0;
      rx_buff = 1'b0;
      cl_nxt       = cl_r;
      cl_nxt.tack1 = tl_r.ack;
      cl_nxt.tack2 = cl_r.tack1;
      cl_nxt.tfs1  = tl_r.fs_tog;
      cl_nxt.tfs2  = cl_r.tfs1;
      cl_nxt.tfs3  = cl_r.tfs2;
      cl_nxt.rw1   = rl_r.word_tog;
      cl_nxt.rw2   = cl_r.rw1;
      cl_nxt.rw3   = cl_r.rw2;
      cl_nxt.rfs1  = rl_r.fs_tog;
      cl_nxt.rfs2  = cl_r.rfs1;
      cl_nxt.rfs3  = cl_r.rfs2;
      tx_fse = cl_r.tfs2 != cl_r.tfs3;
      rx_fse = cl_r.rfs2 != cl_r.rfs3;
      rx_new = cl_r.rw2 != cl_r.rw3;
      tx_wev = cl_r.tx_full && (cl_r.tack2 == cl_r.tx_req);
      rx_wev = rx_new;
      cl_nxt.mem_rd = 1'b0;
      cl_nxt.mem_wr = 1'b0;
      cl_nxt.rd_cap = cl_r.mem_rd;

      // Enables arm on their rising edge and reload the pointer
      cl_nxt.tx_en_d = ab_tx_en;
      cl_nxt.rx_en_d = ab_rx_en;
      if (ab_tx_en && !cl_r.tx_en_d) begin
         cl_nxt.tx_act = 1'b1;
         cl_nxt.tx_ptr = ab_tx_start;
      end else if (!ab_tx_en) begin
         cl_nxt.tx_act = 1'b0;
      end
      if (ab_rx_en && !cl_r.rx_en_d) begin
         cl_nxt.rx_act = 1'b1;
         cl_nxt.rx_ptr = ab_rx_start;
      end else if (!ab_rx_en) begin
         cl_nxt.rx_act = 1'b0;
      end

      if (tx_wev) begin
         cl_nxt.tx_full = 1'b0;
      end
      if (cpu_tx_wr && !cl_r.tx_full && !cl_r.tx_act) begin
         cl_nxt.tx_reg  = cpu_tx_wdata;
         cl_nxt.tx_full = 1'b1;
         cl_nxt.tx_req  = ~cl_r.tx_req;
      end

      // Receive word: set wins over a same-cycle software read
      if (cpu_rx_rd) begin
         cl_nxt.rx_full = 1'b0;
      end
      if (rx_new) begin
         cl_nxt.rx_reg  = rl_r.hold;
         cl_nxt.rx_full = 1'b1;
         if (cl_r.rx_act) begin
            cl_nxt.mem_wr    = 1'b1;
            cl_nxt.mem_addr  = {asp_pkg::ABU_REGION_BASE[15:11],
                                cl_r.rx_ptr};
            cl_nxt.mem_wdata = rl_r.hold;
            adv = asp_pkg::asp_adv(cl_r.rx_ptr, ab_rx_start, ab_rx_len_m1);
            cl_nxt.rx_ptr = adv[10:0];
            rx_buff = adv[11];
            if (adv[11] && ab_auto_dis) begin
               cl_nxt.rx_act = 1'b0;
            end
         end
      end else if (cl_r.tx_act && !cl_r.tx_full && !cl_r.mem_rd &&
                   !cl_r.rd_cap) begin
         // Receive writes win the memory port; reads wait a cycle
         cl_nxt.mem_rd   = 1'b1;
         cl_nxt.mem_addr = {asp_pkg::ABU_REGION_BASE[15:11],
                            cl_r.tx_ptr};
      end
      if (cl_r.rd_cap) begin
         cl_nxt.tx_reg  = mem_rdata;
         cl_nxt.tx_full = 1'b1;
         cl_nxt.tx_req  = ~cl_r.tx_req;
         adv = asp_pkg::asp_adv(cl_r.tx_ptr, ab_tx_start, ab_tx_len_m1);
         cl_nxt.tx_ptr = adv[10:0];
         tx_bufe = adv[11];
         if (adv[11] && ab_auto_dis) begin
            cl_nxt.tx_act = 1'b0;
         end
      end

      cl_nxt.tx_wev = tx_wev;
      cl_nxt.rx_wev = rx_wev;
      // Word events go to the processor only when not autobuffered
      cl_nxt.tx_int = tx_int_en &&
                      (cl_r.tx_act ? tx_bufe : tx_wev);
      cl_nxt.rx_int = rx_int_en &&
                      (cl_r.rx_act ? rx_buff : rx_wev);
      cl_nxt.mis_int = misalign_int_en &&
                       ((tx_fse && cl_r.tx_act &&
                         cl_r.tx_ptr != ab_tx_start) ||
                        (rx_fse && cl_r.rx_act &&
                         cl_r.rx_ptr != ab_rx_start));

      // Half bit period is cfg_clk_div + 1 cycles
      if (cl_r.div_cnt >= cfg_clk_div) begin
         cl_nxt.div_cnt = asp_pkg::DIV_RST;
         cl_nxt.bit_lvl = ~cl_r.bit_lvl;
         if (cl_r.bit_lvl) begin
            if (cl_r.fs_cnt >= cfg_fs_period) begin
               cl_nxt.fs_cnt = asp_pkg::DIV_RST;
            end else begin
               cl_nxt.fs_cnt = 8'(cl_r.fs_cnt + asp_pkg::DIV_ONE);
            end
         end
      end else begin
         cl_nxt.div_cnt = 8'(cl_r.div_cnt + asp_pkg::DIV_ONE);
      end
      cl_nxt.gbclk = cl_nxt.bit_lvl ^ cfg_clk_pol;
      cl_nxt.gfs   = (cl_nxt.fs_cnt == asp_pkg::DIV_RST) ^ cfg_fs_pol;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cl_r <= asp_pkg::CLK_RST;
      end else begin
         cl_r <= cl_nxt;
      end
   end

   assign tx_dout            = tl_r.sh[15];
   assign gen_bclk           = cl_r.gbclk;
   assign gen_fsync          = cl_r.gfs;
   assign tx_data_reg        = cl_r.tx_reg;
   assign rx_data_reg        = cl_r.rx_reg;
   assign tx_full            = cl_r.tx_full;
   assign rx_full            = cl_r.rx_full;
   assign ab_tx_active       = cl_r.tx_act;
   assign ab_rx_active       = cl_r.rx_act;
   assign ab_tx_ptr          = cl_r.tx_ptr;
   assign ab_rx_ptr          = cl_r.rx_ptr;
   assign mem_addr           = cl_r.mem_addr;
   assign mem_rd             = cl_r.mem_rd;
   assign mem_wr             = cl_r.mem_wr;
   assign mem_wdata          = cl_r.mem_wdata;
   assign tx_interrupt       = cl_r.tx_int;
   assign rx_interrupt       = cl_r.rx_int;
   assign misalign_interrupt = cl_r.mis_int;
   assign tx_word_event      = cl_r.tx_wev;
   assign rx_word_event      = cl_r.rx_wev;

endmodule
`default_nettype wire

// file: tb_asp_serial_port.sv
// Self-checking bench for the autobuffered serial port.
// Codec model on the link pins, a small memory on the autobuffer port.
`timescale 1ns/10ps
`default_nettype none
module tb_asp_serial_port;
   logic        clk, reset, tx_bclk, tx_fsync, tx_dout, rx_bclk, rx_fsync;
   logic        rx_din, cfg_continuous, cfg_fs_pol, cfg_clk_pol, gen_bclk;
   logic        gen_fsync, cpu_tx_wr, cpu_rx_rd, tx_full, rx_full;
   logic        ab_tx_en, ab_rx_en, ab_auto_dis, ab_tx_active, ab_rx_active;
   logic        mem_rd, mem_wr, tx_int_en, rx_int_en, misalign_int_en;
   logic        tx_interrupt, rx_interrupt, misalign_interrupt;
   logic        tx_word_event, rx_word_event;
   logic [1:0]  cfg_len;
   logic [7:0]  cfg_clk_div, cfg_fs_period;
   logic [10:0] ab_tx_start, ab_tx_len_m1, ab_rx_start, ab_rx_len_m1;
   logic [10:0] ab_tx_ptr, ab_rx_ptr;
   logic [15:0] cpu_tx_wdata, tx_data_reg, rx_data_reg, mem_addr;
   logic [15:0] mem_wdata, mem_rdata;
   logic [15:0] mem [2048];
   logic [15:0] rxq [$];
   int          n_fail, n_checks, n_txi, n_rxi, n_mis;

   asp_serial_port asp_serial_port_inst (.*);
   asp_codec_model asp_codec_model_inst (.tx_bclk(tx_bclk),
      .tx_fsync(tx_fsync), .tx_dout(tx_dout), .rx_bclk(rx_bclk),
      .rx_fsync(rx_fsync), .rx_din(rx_din), .fs_pol(cfg_fs_pol));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Read data stands only the cycle after mem_rd; otherwise scrambled
   always @(posedge clk) begin
      if (mem_wr) mem[mem_addr[10:0]] = mem_wdata;
      mem_rdata <= mem_rd ? mem[mem_addr[10:0]] : ~mem_rdata;
      if (rx_word_event) rxq.push_back(rx_data_reg);
      n_txi += int'(tx_interrupt);
      n_rxi += int'(rx_interrupt);
      n_mis += int'(misalign_interrupt);
   end

   function automatic int nbits(input logic [1:0] len);
      return (len == 2'h3) ? 16 : 8 + 2 * int'(len);
   endfunction

   function automatic logic [15:0] fit(input logic [1:0] len,
                                       input logic [15:0] d);
      return d & 16'((32'h1 << nbits(len)) - 1);
   endfunction

   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cpu_write(input logic [15:0] d);
      @(negedge clk);
      cpu_tx_wr = 1'b1;
      cpu_tx_wdata = d;
      @(negedge clk);
      cpu_tx_wr = 1'b0;
   endtask

   task automatic rx_read();
      @(negedge clk);
      cpu_rx_rd = 1'b1;
      @(negedge clk);
      cpu_rx_rd = 1'b0;
   endtask

   task automatic zero();
      {n_txi, n_rxi, n_mis} = '0;
      rxq.delete();
   endtask

   task automatic wait_rx(input int n);
      int k;
      k = 0;
      while (rxq.size() < n && k < 300) begin
         @(negedge clk);
         k++;
      end
   endtask

   initial begin
      #60000;
      n_fail++;
      $display("unexpected run time: expected finish, seen timeout");
      finish_test();
   end

   initial begin
      logic [15:0] w, r;
      int          k, s;
      {reset, cfg_continuous, cfg_fs_pol, cfg_clk_pol, cpu_tx_wr} = 5'h10;
      {cpu_rx_rd, ab_tx_en, ab_rx_en, ab_auto_dis} = 4'h0;
      {tx_int_en, rx_int_en, misalign_int_en} = 3'h7;
      {cfg_len, cfg_clk_div, cfg_fs_period} = 18'h00307;
      {ab_tx_start, ab_tx_len_m1, ab_rx_start, ab_rx_len_m1} = '0;
      {cpu_tx_wdata, mem_rdata, n_fail, n_checks} = '0;
      fork
         asp_codec_model_inst.pulse();
         repeat (8) @(negedge clk);
      join
      reset = 1'b0;
      void'($urandom(4));
      for (int i = 0; i < 4; i++) begin
         cfg_len = 2'(i);
         cfg_fs_pol = i[0];
         tx_int_en = (i != 2);
         w = (i == 0) ? 16'hff81 : 16'($urandom);
         r = (i == 0) ? 16'hffff : 16'($urandom);
         zero();
         cpu_write(w);
         if (i == 3) cpu_write(~w);
         check("tx_full", 16'h1, {15'h0, tx_full});
         check("tx_data_reg", w, tx_data_reg);
         asp_codec_model_inst.rx_w[0] = r;
         asp_codec_model_inst.frame(1, nbits(2'(i)), 1'b0);
         wait_rx(1);
         check("rx word", fit(2'(i), r), rxq[0]);
         check("tx word", fit(2'(i), w), asp_codec_model_inst.tx_w[0]);
         check("rx_interrupt count", 16'h1, 16'(n_rxi));
         check("tx_interrupt count", 16'(i != 2), 16'(n_txi));
         check("misalign count", 16'h0, 16'(n_mis));
         rx_read();
         check("rx_full", 16'h0, {15'h0, rx_full});
         $display("test software length %0d done", i);
      end
      {cfg_continuous, cfg_fs_pol, cfg_len} = 4'hb;
      zero();
      cpu_write(16'h8001);
      for (k = 0; k < 3; k++)
         asp_codec_model_inst.rx_w[k] = 16'($urandom);
      asp_codec_model_inst.frame(3, 16, 1'b1);
      wait_rx(3);
      for (k = 0; k < 3; k++)
         check("stream word", asp_codec_model_inst.rx_w[k], rxq[k]);
      check("stream tx", 16'h8001, asp_codec_model_inst.tx_w[0]);
      rx_read();
      $display("test continuous done");
      cfg_continuous = 1'b0;
      // Receiver keeps framing until a packet ends in burst mode
      repeat (3) asp_codec_model_inst.pulse();
      wait_rx(4);
      zero();
      s = $urandom_range(0, 1019);
      {ab_tx_start, ab_rx_start} = {11'(s), 11'(s + 1024)};
      {ab_tx_len_m1, ab_rx_len_m1} = {11'h003, 11'h003};
      for (k = 0; k < 4; k++) begin
         mem[s + k] = 16'($urandom);
         asp_codec_model_inst.rx_w[k] = 16'($urandom);
      end
      ab_auto_dis = 1'b1;
      @(negedge clk);
      {ab_tx_en, ab_rx_en} = 2'h3;
      repeat (4) @(negedge clk);
      check("rx pointer", 16'(s + 1024), {5'h0, ab_rx_ptr});
      asp_codec_model_inst.frame(4, 16, 1'b0);
      wait_rx(4);
      repeat (10) @(negedge clk);
      for (k = 0; k < 4; k++) begin
         check("buffer word", asp_codec_model_inst.rx_w[k], mem[s + 1024 + k]);
         check("buffer tx", mem[s + k], asp_codec_model_inst.tx_w[k]);
      end
      check("rx buffer interrupts", 16'h1, 16'(n_rxi));
      // Buffer empty, then the last word once auto-disabled
      check("tx buffer interrupts", 16'h2, 16'(n_txi));
      check("autobuffer active", 16'h0, {14'h0, ab_tx_active, ab_rx_active});
      check("tx pointer", 16'(s), {5'h0, ab_tx_ptr});
      check("misalign seen", 16'h1, {15'h0, n_mis != 0});
      {ab_tx_en, ab_rx_en, ab_auto_dis} = 3'h0;
      $display("test autobuffer done");
      cfg_clk_div = 8'($urandom_range(1, 6));
      repeat (20) @(negedge clk);
      for (int j = 0; j < 2; j++) begin
         w[0] = gen_bclk;
         k = 0;
         while (gen_bclk === w[0] && k < 50) begin
            @(negedge clk);
            k++;
         end
      end
      check("gen_bclk half period", 16'(cfg_clk_div) + 16'h1, 16'(k));
      k = 0;
      repeat ((int'(cfg_fs_period) + 1) * (int'(cfg_clk_div) + 1) * 2) begin
         @(negedge clk);
         k += int'(gen_fsync);
      end
      check("gen_fsync active", 16'(2 * int'(cfg_clk_div) + 2), 16'(k));
      $display("test clock generator done");
      finish_test();
   end
endmodule
`default_nettype wire
